// [core/gpcd_pkg.sv]
// Constants, types and shared helpers for the general-purpose port block.
// What this block does
// - Mode field 00 input, 01 output, 10 alternate function, 11 analog.
// - Pull field 00 none, 01 up, 10 down, 11 reserved acts as none.
// - Output-type 0 drives push-pull; 1 drives low only, high floats.
// - In output mode the pin carries its output data register bit.
// - Every non-analog pin level is sampled into the input data register each clock.
// - Reset leaves pins input pull-up; debug pins come up function 0, with clock pin 3 pulled down.
// - One of eight functions per pin; low and high select registers.
// - Function select resets to 0 and acts only in alternate mode.
// - Power pull-control bit set takes pulls from power registers.
// - Wakeup and oscillator functions from other blocks override the port.
// - Four 32-bit control registers for 16 pins; pulls any direction.
// - 16-bit data registers; output read-write, input read-only.
// - Set/clear register: 1 in set bit sets, 1 in clear bit clears.
// - Writing 0 to a set/clear bit leaves the output bit unchanged.
// - Set and clear of one pin in one write: set wins.
// - Set/clear acts once, never locks; output register stays writable.
// - All set/clear changes of one write land together.
// - The processor event output is routable to a pin as a function.
// - Type and speed are ignored in input and analog modes.
// - Registers accept word, half-word and byte writes.
// - Analog mode disables sampling; input bit reads zero.
package gpcd_pkg;

   localparam int NUM_PINS = 16;
   localparam int NUM_FUNCS = 8;
   localparam int FSEL_W = 4;
   localparam int PINS_PER_FSEL = 8;

   // Register indexes on the native register port.
   localparam logic [3:0] PIN_MODE_IDX = 4'h0;
   localparam logic [3:0] OUTPUT_TYPE_IDX = 4'h1;
   localparam logic [3:0] OUTPUT_SPEED_IDX = 4'h2;
   localparam logic [3:0] PULL_SELECT_IDX = 4'h3;
   localparam logic [3:0] PIN_INPUT_IDX = 4'h4;
   localparam logic [3:0] PIN_OUTPUT_IDX = 4'h5;
   localparam logic [3:0] BIT_SET_CLEAR_IDX = 4'h6;
   localparam logic [3:0] FUNC_SELECT_LOW_IDX = 4'h8;
   localparam logic [3:0] FUNC_SELECT_HIGH_IDX = 4'h9;

   // Reset values: debug data pin 2 and debug clock pin 3 in alternate mode.
   localparam logic [31:0] PIN_MODE_RESET = 32'h000000a0;
   localparam logic [31:0] PULL_SELECT_RESET = 32'h55555595;
   localparam logic [15:0] OUTPUT_TYPE_RESET = 16'h0000;
   localparam logic [31:0] OUTPUT_SPEED_RESET = 32'h00000000;
   localparam logic [31:0] FUNC_SELECT_RESET = 32'h00000000;
   localparam logic [15:0] PIN_OUTPUT_RESET = 16'h0000;

   // Field positions of the set/clear register.
   localparam int SET_LSB = 0;
   localparam int CLEAR_LSB = 16;

   // Function channel that carries the processor event output.
   localparam logic [2:0] EVENT_FUNC = 3'h7;

   typedef enum logic [1:0] {
      GPCD_MODE_INPUT = 2'b00,
      GPCD_MODE_OUTPUT = 2'b01,
      GPCD_MODE_ALT = 2'b10,
      GPCD_MODE_ANALOG = 2'b11
   } gpcd_mode_type;

   typedef enum logic [1:0] {
      GPCD_PULL_NONE = 2'b00,
      GPCD_PULL_UP = 2'b01,
      GPCD_PULL_DOWN = 2'b10,
      GPCD_PULL_RSVD = 2'b11
   } gpcd_pull_type;

   // Merge a write into a 32-bit register, honouring byte enables.
   function automatic logic [31:0] lane_merge(input logic [31:0] old_val,
                                              input logic [31:0] new_val,
                                              input logic [3:0] be);
      logic [31:0] res;
      res = old_val;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            res[b*8 +: 8] = new_val[b*8 +: 8];
         end
      end
      return res;
   endfunction : lane_merge

   // Expand byte enables into a bit mask.
   function automatic logic [31:0] lane_mask(input logic [3:0] be);
      logic [31:0] res;
      res = 32'h00000000;
      for (int b = 0; b < 4; b++) begin
         res[b*8 +: 8] = {8{be[b]}};
      end
      return res;
   endfunction : lane_mask

endpackage : gpcd_pkg

// [core/gpcd_sync.sv]
// Two-stage synchroniser for the asynchronous pin levels.
`timescale 1ns/100ps
module gpcd_sync
   import gpcd_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [NUM_PINS-1:0] async_in,
   output logic [NUM_PINS-1:0] sync_out
);

   logic [NUM_PINS-1:0] meta;

   // The first stage feeds only the second; nothing else may look at it.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta <= '0;
         sync_out <= '0;
      end else begin
         meta <= async_in;
         sync_out <= meta;
      end
   end

endmodule : gpcd_sync

// [core/gpcd_pin_cell.sv]
// Pad control for one pin: direction, drive type, pulls and speed.
`timescale 1ns/100ps
module gpcd_pin_cell
   import gpcd_pkg::*;
(
   input wire logic [1:0] mode,
   input wire logic otype,
   input wire logic [1:0] speed,
   input wire logic [1:0] pull_field,
   input wire logic pwr_pull_ctrl,
   input wire logic pwr_up,
   input wire logic pwr_down,
   input wire logic odr_bit,
   input wire logic af_data,
   input wire logic af_en,
   input wire logic ovr_en,
   input wire logic ovr_out,
   input wire logic ovr_oe,
   input wire logic ovr_pu,
   input wire logic ovr_pd,
   output logic pad_out,
   output logic pad_oe,
   output logic pad_pu,
   output logic pad_pd,
   output logic [1:0] pad_speed,
   output logic pad_analog
);

   logic drv_en;
   logic drv_data;
   logic [1:0] pull_code;

   // Pick the drive source and apply push-pull or open-drain.
   always_comb begin
      drv_en = 1'b0;
      drv_data = 1'b0;
      pad_speed = 2'b00;
      unique case (gpcd_mode_type'(mode))
         GPCD_MODE_OUTPUT: begin
            drv_en = 1'b1;
            drv_data = odr_bit;
            pad_speed = speed;
         end
         GPCD_MODE_ALT: begin
            drv_en = af_en;
            drv_data = af_data;
            pad_speed = speed;
         end
         GPCD_MODE_INPUT, GPCD_MODE_ANALOG: begin
            drv_en = 1'b0;
         end
      endcase
      pull_code = pwr_pull_ctrl ? {pwr_down, pwr_up} : pull_field;
      if (ovr_en) begin
         // Functions owned by other blocks win over all port settings.
         pad_out = ovr_out;
         pad_oe = ovr_oe;
         pad_pu = ovr_pu;
         pad_pd = ovr_pd;
         pad_speed = 2'b00;
         pad_analog = 1'b0;
      end else begin
         if (otype) begin
            pad_out = 1'b0;
            pad_oe = drv_en & ~drv_data;
         end else begin
            pad_out = drv_data;
            pad_oe = drv_en;
         end
         // Pulls act whatever the direction; reserved code means none.
         pad_pu = (gpcd_pull_type'(pull_code) == GPCD_PULL_UP);
         pad_pd = (gpcd_pull_type'(pull_code) == GPCD_PULL_DOWN);
         pad_analog = (gpcd_mode_type'(mode) == GPCD_MODE_ANALOG);
      end
   end

endmodule : gpcd_pin_cell

// [core/gpcd_port.sv]
// Sixteen-pin general-purpose port: registers, function mux and pad control.
`timescale 1ns/100ps
module gpcd_port
   import gpcd_pkg::*;
(
   input wire logic MCLK,
   input wire logic RST,
   // Native register port.
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [3:0] REG_ADDR,
   input wire logic [3:0] REG_BE,
   input wire logic [31:0] REG_WDATA,
   output logic [31:0] REG_RDATA,
   output logic REG_ERR,
   // Pins.
   input wire logic [NUM_PINS-1:0] PIN_IN,
   output logic [NUM_PINS-1:0] PIN_OUT,
   output logic [NUM_PINS-1:0] PIN_OE,
   output logic [NUM_PINS-1:0] PIN_PU,
   output logic [NUM_PINS-1:0] PIN_PD,
   output logic [2*NUM_PINS-1:0] PIN_SPEED,
   output logic [NUM_PINS-1:0] PIN_ANALOG,
   // Power block pull control.
   input wire logic POWER_PULL_CONTROL_BIT,
   input wire logic [NUM_PINS-1:0] POWER_PULLUP_REG,
   input wire logic [NUM_PINS-1:0] POWER_PULLDOWN_REG,
   // Wakeup and oscillator overrides from other blocks.
   input wire logic [NUM_PINS-1:0] OVR_EN,
   input wire logic [NUM_PINS-1:0] OVR_OUT,
   input wire logic [NUM_PINS-1:0] OVR_OE,
   input wire logic [NUM_PINS-1:0] OVR_PU,
   input wire logic [NUM_PINS-1:0] OVR_PD,
   // Peripheral functions, eight channels per pin, channel c of pin i at i*8+c.
   input wire logic [NUM_PINS*NUM_FUNCS-1:0] AF_OUT,
   input wire logic [NUM_PINS*NUM_FUNCS-1:0] AF_OE,
   output logic [NUM_PINS*NUM_FUNCS-1:0] AF_IN,
   input wire logic CPU_EVENT_OUTPUT
);

   logic [31:0] pin_mode_reg;
   logic [NUM_PINS-1:0] output_type_reg;
   logic [31:0] output_speed_reg;
   logic [31:0] pull_select_reg;
   logic [NUM_PINS-1:0] pin_input_reg;
   logic [NUM_PINS-1:0] pin_output_reg;
   logic [31:0] func_select_low_reg;
   logic [31:0] func_select_high_reg;
   logic [NUM_PINS-1:0] pin_sync;
   logic [NUM_PINS-1:0] analog_pin;
   logic [NUM_PINS-1:0] set_bit;
   logic [NUM_PINS-1:0] clear_bit;
   logic [NUM_PINS-1:0] next_pin_output;
   logic [31:0] next_rdata;
   logic addr_ok;
   logic [31:0] be_mask;
   logic [NUM_PINS*FSEL_W-1:0] func_sel;

   // Write strobes decoded once for every writable register.
   logic wr_mode;
   logic wr_type;
   logic wr_speed;
   logic wr_pull;
   logic wr_out;
   logic wr_setclr;
   logic wr_fsel_lo;
   logic wr_fsel_hi;

   assign wr_mode = REG_WR && (REG_ADDR == PIN_MODE_IDX);
   assign wr_type = REG_WR && (REG_ADDR == OUTPUT_TYPE_IDX);
   assign wr_speed = REG_WR && (REG_ADDR == OUTPUT_SPEED_IDX);
   assign wr_pull = REG_WR && (REG_ADDR == PULL_SELECT_IDX);
   assign wr_out = REG_WR && (REG_ADDR == PIN_OUTPUT_IDX);
   assign wr_setclr = REG_WR && (REG_ADDR == BIT_SET_CLEAR_IDX);
   assign wr_fsel_lo = REG_WR && (REG_ADDR == FUNC_SELECT_LOW_IDX);
   assign wr_fsel_hi = REG_WR && (REG_ADDR == FUNC_SELECT_HIGH_IDX);
   assign be_mask = lane_mask(REG_BE);

   // Mode register; software is expected to write it last when enabling a function.
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         pin_mode_reg <= PIN_MODE_RESET;
      end else if (wr_mode) begin
         pin_mode_reg <= lane_merge(pin_mode_reg, REG_WDATA, REG_BE);
      end
   end

   // Output type register, one bit per pin in the low half-word.
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         output_type_reg <= OUTPUT_TYPE_RESET;
      end else if (wr_type) begin
         output_type_reg <= NUM_PINS'(lane_merge({16'h0000, output_type_reg}, REG_WDATA,
                                                 REG_BE));
      end
   end

   // Speed register, two bits per pin.
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         output_speed_reg <= OUTPUT_SPEED_RESET;
      end else if (wr_speed) begin
         output_speed_reg <= lane_merge(output_speed_reg, REG_WDATA, REG_BE);
      end
   end

   // Pull register, two bits per pin.
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         pull_select_reg <= PULL_SELECT_RESET;
      end else if (wr_pull) begin
         pull_select_reg <= lane_merge(pull_select_reg, REG_WDATA, REG_BE);
      end
   end

   // Function select registers, four bits per pin.
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         func_select_low_reg <= FUNC_SELECT_RESET;
         func_select_high_reg <= FUNC_SELECT_RESET;
      end else begin
         if (wr_fsel_lo) begin
            func_select_low_reg <= lane_merge(func_select_low_reg, REG_WDATA, REG_BE);
         end
         if (wr_fsel_hi) begin
            func_select_high_reg <= lane_merge(func_select_high_reg, REG_WDATA, REG_BE);
         end
      end
   end

   // Pins 0-7 take their selection from the low register, 8-15 from the high one.
   assign func_sel = {func_select_high_reg, func_select_low_reg};

   // Set/clear strobes; disabled byte lanes count as zero, which changes nothing.
   assign set_bit = wr_setclr ? REG_WDATA[SET_LSB +: NUM_PINS] & be_mask[SET_LSB +: NUM_PINS]
                              : '0;
   assign clear_bit = wr_setclr ? REG_WDATA[CLEAR_LSB +: NUM_PINS]
                                  & be_mask[CLEAR_LSB +: NUM_PINS] : '0;

   // Next output data: a direct write, or one atomic set/clear update.
   always_comb begin
      next_pin_output = pin_output_reg;
      if (wr_out) begin
         // Direct writes are always accepted; set/clear leaves no lock behind.
         next_pin_output = NUM_PINS'(lane_merge({16'h0000, pin_output_reg}, REG_WDATA,
                                                REG_BE));
      end else if (wr_setclr) begin
         // Clear first, then set, so a pin with both bits ends high.
         next_pin_output = (pin_output_reg & ~clear_bit) | set_bit;
      end
   end

   // All bits of one set/clear write land on the same edge.
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         pin_output_reg <= PIN_OUTPUT_RESET;
      end else begin
         pin_output_reg <= next_pin_output;
      end
   end

   // Pin levels come from outside the clock domain.
   gpcd_sync u_sync (
      .clk(MCLK),
      .rst(RST),
      .async_in(PIN_IN),
      .sync_out(pin_sync)
   );

   // Input data is refreshed every clock; analog pins read as zero.
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         pin_input_reg <= '0;
      end else begin
         pin_input_reg <= pin_sync & ~analog_pin;
      end
   end

   // Per-pin function mux and pad control.
   for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
      logic [2:0] sel;
      logic af_data;
      logic af_en;
      logic [1:0] mode;

      assign sel = func_sel[i*FSEL_W +: 3];
      assign mode = pin_mode_reg[2*i +: 2];
      assign analog_pin[i] = (gpcd_mode_type'(mode) == GPCD_MODE_ANALOG);

      // The event channel carries the processor event, always driven.
      assign af_data = (sel == EVENT_FUNC) ? CPU_EVENT_OUTPUT
                                          : AF_OUT[i*NUM_FUNCS + int'(sel)];
      assign af_en = (sel == EVENT_FUNC) ? 1'b1 : AF_OE[i*NUM_FUNCS + int'(sel)];

      // Only the selected channel sees the pin; the others read zero.
      for (genvar c = 0; c < NUM_FUNCS; c++) begin : g_in
         assign AF_IN[i*NUM_FUNCS + c] = (gpcd_mode_type'(mode) == GPCD_MODE_ALT)
                                         && (sel == 3'(c)) && pin_sync[i];
      end

      gpcd_pin_cell u_cell (
         .mode(mode),
         .otype(output_type_reg[i]),
         .speed(output_speed_reg[2*i +: 2]),
         .pull_field(pull_select_reg[2*i +: 2]),
         .pwr_pull_ctrl(POWER_PULL_CONTROL_BIT),
         .pwr_up(POWER_PULLUP_REG[i]),
         .pwr_down(POWER_PULLDOWN_REG[i]),
         .odr_bit(pin_output_reg[i]),
         .af_data(af_data),
         .af_en(af_en),
         .ovr_en(OVR_EN[i]),
         .ovr_out(OVR_OUT[i]),
         .ovr_oe(OVR_OE[i]),
         .ovr_pu(OVR_PU[i]),
         .ovr_pd(OVR_PD[i]),
         .pad_out(PIN_OUT[i]),
         .pad_oe(PIN_OE[i]),
         .pad_pu(PIN_PU[i]),
         .pad_pd(PIN_PD[i]),
         .pad_speed(PIN_SPEED[2*i +: 2]),
         .pad_analog(PIN_ANALOG[i])
      );
   end

   // Read mux; narrow registers sit in the low bits.
   always_comb begin
      next_rdata = 32'h00000000;
      addr_ok = 1'b1;
      unique case (REG_ADDR)
         PIN_MODE_IDX: next_rdata = pin_mode_reg;
         OUTPUT_TYPE_IDX: next_rdata = {16'h0000, output_type_reg};
         OUTPUT_SPEED_IDX: next_rdata = output_speed_reg;
         PULL_SELECT_IDX: next_rdata = pull_select_reg;
         PIN_INPUT_IDX: next_rdata = {16'h0000, pin_input_reg};
         PIN_OUTPUT_IDX: next_rdata = {16'h0000, pin_output_reg};
         BIT_SET_CLEAR_IDX: next_rdata = 32'h00000000;
         FUNC_SELECT_LOW_IDX: next_rdata = func_select_low_reg;
         FUNC_SELECT_HIGH_IDX: next_rdata = func_select_high_reg;
         default: addr_ok = 1'b0;
      endcase
   end

   // Read data is registered and holds until the next read.
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         REG_RDATA <= 32'h00000000;
      end else if (REG_RD) begin
         REG_RDATA <= next_rdata;
      end
   end

   // Unmapped accesses, and writes to the read-only input register, flag an error.
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         REG_ERR <= 1'b0;
      end else begin
         REG_ERR <= ((REG_RD || REG_WR) && !addr_ok)
                    || (REG_WR && REG_ADDR == PIN_INPUT_IDX);
      end
   end

endmodule : gpcd_port

// [dv/gpcd_props.sv]
// Checker of the general-purpose port, bound to the top module's ports.
`timescale 1ns/100ps
module gpcd_props
   import gpcd_pkg::*;
(
   input wire logic MCLK,
   input wire logic RST,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [3:0] REG_ADDR,
   input wire logic [3:0] REG_BE,
   input wire logic [31:0] REG_WDATA,
   input wire logic [31:0] REG_RDATA,
   input wire logic REG_ERR,
   input wire logic [NUM_PINS-1:0] PIN_IN,
   input wire logic [NUM_PINS-1:0] PIN_OE,
   input wire logic [NUM_PINS-1:0] PIN_PU,
   input wire logic [NUM_PINS-1:0] PIN_PD,
   input wire logic [NUM_PINS-1:0] PIN_ANALOG
);
   default clocking dc @(posedge MCLK);
   endclocking
   default disable iff (RST);

   // Index 7 and everything above 9 decode to nothing.
   logic bad_addr;
   assign bad_addr = (REG_ADDR == 4'h7) || (REG_ADDR > 4'h9);

   // Error pulses and the write-only trigger register.
   property p_input_wr_err;
      REG_WR && REG_ADDR == 4'h4 |=> REG_ERR;
   endproperty
   a_input_wr_err: assert property (p_input_wr_err) else $error("input write not flagged");
   property p_unmapped_err;
      (REG_WR || REG_RD) && bad_addr |=> REG_ERR;
   endproperty
   a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped not flagged");
   property p_set_clear_zero;
      REG_RD && REG_ADDR == 4'h6 |=> REG_RDATA == 32'h0 && !REG_ERR;
   endproperty
   a_set_clear_zero: assert property (p_set_clear_zero) else $error("set/clear not zero");

   // Pad relations that hold in every cycle.
   property p_analog_no_drive;
      (PIN_ANALOG & PIN_OE) == 16'h0;
   endproperty
   a_analog_no_drive: assert property (p_analog_no_drive) else $error("analog pin driven");
   property p_pull_single;
      (PIN_PU & PIN_PD) == 16'h0;
   endproperty
   a_pull_single: assert property (p_pull_single) else $error("both pulls on");

   // A read of the input register after the pins have settled shows them, analog pins as 0.
   sequence s_quiet;
      ($stable(PIN_IN) && $stable(PIN_ANALOG))[*5];
   endsequence
   property p_input_sample;
      s_quiet ##0 (REG_RD && REG_ADDR == 4'h4) |=>
         REG_RDATA == {16'h0, $past(PIN_IN & ~PIN_ANALOG)};
   endproperty
   a_input_sample: assert property (p_input_sample) else $error("input reg stale");

   // Back-to-back write and read of the output register, and an atomic set/clear.
   property p_odr_write;
      REG_WR && !REG_RD && REG_ADDR == 4'h5 && REG_BE == 4'hf ##1 REG_RD && REG_ADDR == 4'h5
         |=> REG_RDATA[15:0] == $past(REG_WDATA[15:0], 2);
   endproperty
   a_odr_write: assert property (p_odr_write) else $error("output register write lost");
   property p_set_clear;
      REG_RD && !REG_WR && REG_ADDR == 4'h5
         ##1 REG_WR && !REG_RD && REG_ADDR == 4'h6 && REG_BE == 4'hf
         ##1 REG_RD && !REG_WR && REG_ADDR == 4'h5
         |=> REG_RDATA[15:0] == (($past(REG_RDATA[15:0]) & ~$past(REG_WDATA[31:16], 2))
            | $past(REG_WDATA[15:0], 2));
   endproperty
   a_set_clear: assert property (p_set_clear) else $error("set/clear result wrong");

   c_set_clear: cover property (REG_WR && REG_ADDR == 4'h6);
   c_err: cover property (REG_ERR);
   c_analog: cover property (PIN_ANALOG != 16'h0);
endmodule : gpcd_props

bind gpcd_port gpcd_props u_gpcd_props (.MCLK(MCLK), .RST(RST), .REG_WR(REG_WR),
   .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_BE(REG_BE), .REG_WDATA(REG_WDATA),
   .REG_RDATA(REG_RDATA), .REG_ERR(REG_ERR), .PIN_IN(PIN_IN), .PIN_OE(PIN_OE),
   .PIN_PU(PIN_PU), .PIN_PD(PIN_PD), .PIN_ANALOG(PIN_ANALOG));

// [dv/gpcd_pin_model.sv]
// Pin model: resolves each pad from the port's drive, pulls and an outside source.
`timescale 1ns/100ps
module gpcd_pin_model
   import gpcd_pkg::*;
(
   input wire logic [NUM_PINS-1:0] drv,
   input wire logic [NUM_PINS-1:0] oe,
   input wire logic [NUM_PINS-1:0] pu,
   input wire logic [NUM_PINS-1:0] pd,
   input wire logic [NUM_PINS-1:0] src,
   output logic [NUM_PINS-1:0] level
);
   // An open-drain high is not driven, so it falls to the pull or to the outside source.
   // The source is always defined, so a floating pin never reads as a lucky value.
   always_comb begin
      for (int i = 0; i < NUM_PINS; i++) begin
         if (oe[i]) begin
            level[i] = drv[i];
         end else if (pu[i] || pd[i]) begin
            level[i] = pu[i];
         end else begin
            level[i] = src[i];
         end
      end
   end
endmodule : gpcd_pin_model

// [dv/tb.sv]
// Self-checking testbench of the general-purpose port.
`timescale 1ns/100ps
module tb;
   import gpcd_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [3:0] ben = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata, speed, got;
   logic err, pwr_bit = 1'b0, cpu_ev = 1'b0;
   logic [15:0] pin_in, pin_out, pin_oe, pin_pu, pin_pd, pin_analog;
   logic [15:0] ext = 16'h0, pwr_up = 16'h0, pwr_dn = 16'h0;
   logic [15:0] ovr_en = 16'h0, ovr_out = 16'h0, ovr_oe = 16'h0, ovr_pu = 16'h0;
   logic [15:0] ovr_pd = 16'h0;
   logic [127:0] af_out = 128'h10000, af_oe = 128'h10000, af_in;
   int n_mismatch = 0;
   int checks = 0;
   int cyc = 0;

   gpcd_port u_gpcd_port (.MCLK(clk), .RST(rst), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr),
      .REG_BE(ben), .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_ERR(err), .PIN_IN(pin_in),
      .PIN_OUT(pin_out), .PIN_OE(pin_oe), .PIN_PU(pin_pu), .PIN_PD(pin_pd),
      .PIN_SPEED(speed), .PIN_ANALOG(pin_analog), .POWER_PULL_CONTROL_BIT(pwr_bit),
      .POWER_PULLUP_REG(pwr_up), .POWER_PULLDOWN_REG(pwr_dn), .OVR_EN(ovr_en),
      .OVR_OUT(ovr_out), .OVR_OE(ovr_oe), .OVR_PU(ovr_pu), .OVR_PD(ovr_pd),
      .AF_OUT(af_out), .AF_OE(af_oe), .AF_IN(af_in), .CPU_EVENT_OUTPUT(cpu_ev));
   gpcd_pin_model u_gpcd_pin_model (.drv(pin_out), .oe(pin_oe), .pu(pin_pu), .pd(pin_pd),
      .src(ext), .level(pin_in));

   // Free-running clock; the cycle counter cuts a hang short.
   always #10 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         n_mismatch++;
         end_sim();
      end
   end

   // One register cycle, entered at a falling edge; read data is taken a cycle later.
   task automatic acc(input logic w, input logic r, input logic [3:0] a, input logic [3:0] b,
                      input logic [31:0] d);
      wr = w;
      rd = r;
      addr = a;
      ben = b;
      wdata = d;
      @(negedge clk);
      got = rdata;
   endtask : acc

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk

   task automatic t_reset();
      acc(0, 1, 4'h0, 4'h0, 32'h0);
      chk(got, 32'h000000a0);
      acc(0, 1, 4'h3, 4'h0, 32'h0);
      chk(got, 32'h55555595);
      acc(0, 1, 4'h8, 4'h0, 32'h0);
      chk(got, 32'h0);
      acc(0, 1, 4'h9, 4'h0, 32'h0);
      chk(got, 32'h0);
      chk({pin_oe[2], pin_out[2], pin_oe[3]}, 3'b110);
      chk({pin_pu, pin_pd}, 32'hfff70008);
   endtask : t_reset

   task automatic t_out();
      acc(1, 0, 4'h0, 4'hf, 32'h55555555);
      acc(1, 0, 4'h5, 4'hf, 32'h0000a5c3);
      chk(pin_oe, 16'hffff);
      chk(pin_out, 16'ha5c3);
      acc(1, 0, 4'h1, 4'hf, 32'h0000ffff);
      chk(pin_oe, 16'h5a3c);
      acc(1, 0, 4'h2, 4'hf, 32'hffffffff);
      chk(speed, 32'hffffffff);
      acc(1, 0, 4'h0, 4'hf, 32'hffffffff);
      chk({pin_analog, pin_oe}, 32'hffff0000);
      chk(speed, 32'h0);
      acc(1, 0, 4'h0, 4'hf, 32'h0);
      chk({pin_oe, speed[15:0]}, 32'h0);
      acc(1, 0, 4'h1, 4'hf, 32'h0);
   endtask : t_out

   task automatic t_bsc();
      acc(1, 0, 4'h0, 4'hf, 32'h55555555);
      acc(1, 0, 4'h5, 4'hf, 32'h000000ff);
      acc(0, 1, 4'h5, 4'h0, 32'h0);
      chk(got, 32'h000000ff);
      acc(1, 0, 4'h6, 4'hf, 32'h0f0ff000);
      acc(0, 1, 4'h5, 4'h0, 32'h0);
      chk(got, 32'h0000f0f0);
      chk(pin_out, 16'hf0f0);
      acc(1, 0, 4'h6, 4'hf, 32'h00010001);
      acc(1, 0, 4'h6, 4'hf, 32'h0);
      acc(0, 1, 4'h5, 4'h0, 32'h0);
      chk(got, 32'h0000f0f1);
      acc(1, 0, 4'h6, 4'h1, 32'hffff0000);
      acc(1, 0, 4'h5, 4'h2, 32'h00000f00);
      acc(0, 1, 4'h5, 4'h0, 32'h0);
      chk(got, 32'h00000ff1);
      acc(0, 1, 4'h6, 4'h0, 32'h0);
      chk(got, 32'h0);
   endtask : t_bsc

   task automatic t_pull();
      acc(1, 0, 4'h3, 4'hf, 32'h000000e4);
      chk({pin_pu, pin_pd}, 32'h00020004);
      acc(1, 0, 4'h0, 4'hf, 32'h0);
      chk({pin_pu, pin_pd}, 32'h00020004);
      pwr_bit = 1'b1;
      pwr_up = 16'h00f0;
      pwr_dn = 16'h0f00;
      acc(0, 0, 4'h0, 4'h0, 32'h0);
      chk({pin_pu, pin_pd}, 32'h00f00f00);
      pwr_bit = 1'b0;
   endtask : t_pull

   // Function first, then mode, on pin 0 through the low and pin 9 through the high selector.
   task automatic t_af();
      for (int c = 0; c < 8; c++) begin
         af_out = (128'h1 << c) | (128'h1 << (72 + c));
         af_oe = {128{1'b1}};
         cpu_ev = (c == 7);
         acc(1, 0, 4'h8, 4'hf, {29'h0, c[2:0]});
         acc(1, 0, 4'h9, 4'hf, {24'h0, 1'b0, c[2:0], 4'h0});
         acc(1, 0, 4'h0, 4'hf, 32'h00080002);
         acc(0, 0, 4'h0, 4'h0, 32'h0);
         acc(0, 0, 4'h0, 4'h0, 32'h0);
         chk({pin_out[9], pin_out[0]}, 2'b11);
         chk({af_in[79:72], af_in[7:0]}, {2{8'h01 << c}});
      end
      cpu_ev = 1'b0;
      acc(0, 0, 4'h0, 4'h0, 32'h0);
      chk(pin_out[0], 1'b0);
   endtask : t_af

   task automatic t_ovr();
      ovr_en = 16'h0020;
      ovr_out = 16'h0020;
      ovr_oe = 16'h0020;
      ovr_pu = 16'h0020;
      acc(0, 0, 4'h0, 4'h0, 32'h0);
      chk({pin_oe[5], pin_out[5], pin_pu[5]}, 3'b111);
      ovr_pu = 16'h0;
      ovr_pd = 16'h0020;
      acc(0, 0, 4'h0, 4'h0, 32'h0);
      chk({pin_pu[5], pin_pd[5]}, 2'b01);
      ovr_pd = 16'h0;
      ovr_en = 16'h0;
   endtask : t_ovr

   task automatic t_err();
      acc(1, 0, 4'h4, 4'hf, 32'hffffffff);
      chk(err, 1'b1);
      acc(0, 1, 4'h7, 4'h0, 32'h0);
      chk({err, got}, 33'h100000000);
   endtask : t_err

   task automatic t_input();
      acc(1, 0, 4'h3, 4'hf, 32'h0);
      acc(1, 0, 4'h0, 4'hf, 32'h0);
      ext = 16'h3c5a;
      repeat (6) acc(0, 0, 4'h0, 4'h0, 32'h0);
      acc(0, 1, 4'h4, 4'h0, 32'h0);
      chk(got, 32'h00003c5a);
      acc(1, 0, 4'h0, 4'hf, 32'h000000ff);
      repeat (6) acc(0, 0, 4'h0, 4'h0, 32'h0);
      acc(0, 1, 4'h4, 4'h0, 32'h0);
      chk(got, 32'h00003c50);
   endtask : t_input

   task automatic end_sim();
      $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : end_sim

   // Reset for eight cycles, release at a falling edge, then run the scenarios.
   initial begin
      repeat (8) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      t_reset();
      t_out();
      t_bsc();
      t_pull();
      t_af();
      t_ovr();
      t_err();
      t_input();
      acc(0, 0, 4'h0, 4'h0, 32'h0);
      end_sim();
   end
endmodule : tb
